/* logic/ext_bus_timing_regs.svh */
// Purpose: register map, field positions and timing counts
// Assumes: 32-bit APB data, one register per aligned word
// Notes: definitions only
`ifndef EXT_BUS_TIMING_REGS_SVH
`define EXT_BUS_TIMING_REGS_SVH

`define CFG_OFFSET 8'h00
`define STAT_OFFSET 8'h04
`define CFG_RESET 7'h00
`define CFG_CYC_LSB 0
`define CFG_CYC_MSB 3
`define CFG_RWD_BIT 4
`define CFG_TRI_BIT 5
`define CFG_MUX_BIT 6
`define STAT_BUSY_BIT 0
`define STAT_CFG_LSB 8
`define STAT_CFG_MSB 14
// one state time is two oscillator periods
`define ST_CYCLES 6'h02
`define HALF_ST_CYCLES 6'h01
`define CYC_MAX 4'hf

`endif

/* logic/ext_bus_timing_pkg.sv */
// Purpose: types shared by the external bus timing block
// Assumes: nothing
// Notes: timing figures live in ext_bus_timing_regs.svh
package ext_bus_timing_pkg;

    typedef struct packed {
        logic mux_mode;
        logic tristate_time_ctrl;
        logic rw_strobe_delay_ctrl;
        logic [3:0] cycle_time_ctrl;
    } timing_cfg_t;

    typedef struct packed {
        logic ext;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_ALE,
        S_ACC,
        S_TRI
    } bus_state_t;

endpackage

/* logic/phase_timer.sv */
// Purpose: down counter that marks the last cycle of a bus phase
// Assumes: load and done share pclk
// Notes: a load of n gives a phase of n cycles, done on the last
`timescale 1ns/100ps
module phase_timer #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done
);
    logic [W-1:0] cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= load_val;
        end else if (cnt != '0) begin
            cnt <= cnt - W'(1);
        end
    end

    assign done = (cnt == W'(1));
endmodule

/* logic/ext_bus_timing.sv */
// Purpose: sequences external bus cycles with programmable wait states
// Assumes: pclk is the oscillator clock, core holds its request to ready
// Notes: settings are captured at the start of each external cycle
`timescale 1ns/100ps
`include "ext_bus_timing_regs.svh"

module ext_bus_timing (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core request path
    input wire logic core_req,
    input wire ext_bus_timing_pkg::mem_req_t core_cmd,
    output logic core_ready,
    output logic [15:0] core_rdata,
    // external bus pins
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [15:0] bus_addr,
    output logic [15:0] data_out,
    output logic data_oe_n,
    input wire logic [15:0] data_in
);
    import ext_bus_timing_pkg::*;

    timing_cfg_t system_config_reg;
    timing_cfg_t cur_cfg;
    bus_state_t st;
    mem_req_t cur_req;
    logic [15:0] data_meta;
    logic [15:0] data_sync;
    logic [5:0] acc_cyc;
    logic [5:0] strb_cyc;
    logic [5:0] tri_cyc;
    logic tmr_load;
    logic [5:0] tmr_val;
    logic tmr_done;
    logic apb_wr;
    logic strobe_on;

    // access phase in clock cycles: one base state plus the extension
    function automatic logic [5:0] acc_cycles(input timing_cfg_t c);
        logic [5:0] extra;
        extra = {2'b00, `CYC_MAX - c.cycle_time_ctrl};
        return (extra + 6'h01) * `ST_CYCLES;
    endfunction

    // release phase in clock cycles; a clear tri-state bit adds one state time
    function automatic logic [5:0] tri_cycles(input timing_cfg_t c);
        logic [5:0] n;
        n = {5'b0_0000, !c.tristate_time_ctrl};
        n = n + {5'b0_0000, c.mux_mode};
        return n * `ST_CYCLES;
    endfunction

    // apb: zero-wait slave, unmapped addresses answer with pslverr
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    assign pslverr = psel && penable &&
        (paddr != `CFG_OFFSET) && (paddr != `STAT_OFFSET);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_config_reg <= `CFG_RESET;
        end else if (apb_wr && paddr == `CFG_OFFSET) begin
            system_config_reg <= pwdata[`CFG_MUX_BIT:`CFG_CYC_LSB];
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == `CFG_OFFSET) begin
            prdata[`CFG_MUX_BIT:`CFG_CYC_LSB] = system_config_reg;
        end else if (paddr == `STAT_OFFSET) begin
            prdata[`STAT_BUSY_BIT] = (st != S_IDLE);
            prdata[`STAT_CFG_MSB:`STAT_CFG_LSB] = cur_cfg;
        end
    end

    // read data pins come from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_meta <= 16'h0000;
            data_sync <= 16'h0000;
        end else begin
            data_meta <= data_in;
            data_sync <= data_meta;
        end
    end

    phase_timer #(.W(6)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    always_comb begin
        tmr_load = 1'b0;
        tmr_val = `ST_CYCLES;
        unique case (st)
            S_IDLE: begin
                tmr_load = core_req && core_cmd.ext;
                tmr_val = `ST_CYCLES;
            end
            S_ALE: begin
                tmr_load = tmr_done;
                tmr_val = acc_cycles(cur_cfg);
            end
            S_ACC: begin
                tmr_load = tmr_done && (tri_cycles(cur_cfg) != 6'h00);
                tmr_val = tri_cycles(cur_cfg);
            end
            S_TRI: begin
                tmr_load = 1'b0;
                tmr_val = `ST_CYCLES;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= S_IDLE;
        end else begin
            unique case (st)
                S_IDLE: if (core_req && core_cmd.ext) begin
                    st <= S_ALE;
                end
                S_ALE: if (tmr_done) begin
                    st <= S_ACC;
                end
                S_ACC: if (tmr_done) begin
                    st <= (tri_cycles(cur_cfg) != 6'h00) ? S_TRI : S_IDLE;
                end
                S_TRI: if (tmr_done) begin
                    st <= S_IDLE;
                end
            endcase
        end
    end

    // settings frozen for the whole cycle; register writes land at once, the running cycle keeps cur_cfg
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_cfg <= `CFG_RESET;
            cur_req <= '0;
        end else if (st == S_IDLE && core_req && core_cmd.ext) begin
            cur_cfg <= system_config_reg;
            cur_req <= core_cmd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_cyc <= 6'h00;
        end else if (st == S_ACC) begin
            acc_cyc <= acc_cyc + 6'h01;
        end else begin
            acc_cyc <= 6'h00;
        end
    end

    // a clear delay bit holds the strobe off for the first half state;
    // the phase end stays fixed, so the strobe shortens instead
    assign strobe_on = (st == S_ACC) &&
        (cur_cfg.rw_strobe_delay_ctrl ||
         acc_cyc >= `HALF_ST_CYCLES);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_rdata <= 16'h0000;
        end else if (st == S_ACC) begin
            core_rdata <= data_sync;
        end
    end

    // internal requests bypass the bus and complete in the same cycle
    assign core_ready = (st == S_IDLE && core_req && !core_cmd.ext) ||
        (st == S_ACC && tmr_done);

    assign ale = (st == S_ALE);
    assign rd_n = !(strobe_on && !cur_req.we);
    assign wr_n = !(strobe_on && cur_req.we);
    assign bus_addr = cur_req.addr;
    assign data_out = cur_req.wdata;
    assign data_oe_n = !(cur_req.we && (st == S_ACC));

    // helper counters for the checks below
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strb_cyc <= 6'h00;
            tri_cyc <= 6'h00;
        end else begin
            strb_cyc <= (st == S_ACC) ? strb_cyc + 6'(strobe_on) : 6'h00;
            tri_cyc <= (st == S_TRI) ? tri_cyc + 6'h01 : 6'h00;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ale_two_s;
        ale [*2] ##1 !ale;
    endsequence

    ale_state_time_a: assert property ($rose(ale) |-> ale_two_s)
        else $error("ale not one state time");

    access_length_a: assert property (
        (st == S_ACC && tmr_done) |-> acc_cyc + 6'h01 == acc_cycles(cur_cfg))
        else $error("access phase length wrong");

    strobe_delay_a: assert property (
        ($fell(ale) && !cur_cfg.rw_strobe_delay_ctrl)
        |-> (rd_n && wr_n) ##1 (!rd_n || !wr_n))
        else $error("strobe delay wrong");

    strobe_nodelay_a: assert property (
        ($fell(ale) && cur_cfg.rw_strobe_delay_ctrl) |-> (!rd_n || !wr_n))
        else $error("strobe late without delay");

    total_length_a: assert property (
        (st == S_ACC && tmr_done) |-> strb_cyc + 6'h01 +
        6'(!cur_cfg.rw_strobe_delay_ctrl) == acc_cycles(cur_cfg))
        else $error("delay changed access length");

    tri_length_a: assert property (
        (st == S_TRI && tmr_done) |-> tri_cyc + 6'h01 == tri_cycles(cur_cfg))
        else $error("tri-state length wrong");

    internal_fast_a: assert property (
        (st == S_IDLE && core_req && !core_cmd.ext)
        |-> core_ready ##1 (st == S_IDLE && !ale))
        else $error("internal access delayed");

    cfg_frozen_a: assert property (
        (st != S_IDLE && $past(st) != S_IDLE) |-> $stable(cur_cfg))
        else $error("settings changed mid cycle");

    ready_once_a: assert property (
        (core_ready && core_cmd.ext) |=> st != S_ACC)
        else $error("external ready longer than a cycle");
endmodule

/* verification/ext_mem_model.sv */
// Purpose: external memory answering the device's bus cycles
// Assumes: bus_addr and data_out are held by the device through a cycle
// Notes: a released bus shows the inverse of the last value, not a copy
`timescale 1ns/100ps
module ext_mem_model (
    // clock
    input wire logic pclk,
    // bus from the device
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    // bus to the device
    output logic [15:0] data_in
);
    logic [15:0] mem [0:255];
    logic [15:0] last;
    logic drive;
    logic ale_d = 1'b0;

    initial begin
        last = 16'h0000;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h5a00 ^ 16'(i);
        end
    end
    // drives from address latch on, so the synchroniser sees it early;
    // the cycle after latch counts too, as a delayed strobe is still off
    assign drive = ale || ale_d || !rd_n;
    assign data_in = drive ? mem[bus_addr[7:0]] : ~last;
    always @(posedge pclk) begin
        ale_d <= ale;
        if (drive) begin
            last <= mem[bus_addr[7:0]];
        end
        if (!wr_n && !data_oe_n) begin
            mem[bus_addr[7:0]] <= data_out;
        end
    end
endmodule

/* verification/tb_ext_bus_timing.sv */
// Purpose: self-checking bench for the external bus timing block
// Assumes: state time of two pclk cycles, access base of one state
// Notes: cycle counts are taken at falling edges between updates
`timescale 1ns/100ps
`include "ext_bus_timing_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    err_count++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_ext_bus_timing;
    import ext_bus_timing_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, core_ready, ale, rd_n, wr_n, data_oe_n;
    logic core_req = 1'b0;
    mem_req_t core_cmd = '0;
    logic [15:0] core_rdata, bus_addr, data_out, data_in;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n, al, st, ex;
    logic [31:0] q;
    logic e;
    logic [15:0] r;

    always #50 pclk = ~pclk;

    ext_bus_timing dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_req(core_req), .core_cmd(core_cmd), .core_ready(core_ready),
        .core_rdata(core_rdata), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .bus_addr(bus_addr), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in));
    ext_mem_model mem_u (.pclk(pclk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .bus_addr(bus_addr), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in));

    task automatic complete_run();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // request stays up after ready so a following call runs back to back
    task automatic core_op(input logic ext, input logic we,
                           input logic [15:0] a, input logic [15:0] d);
        core_req <= 1'b1;
        core_cmd <= {ext, we, a, d};
        n = 0;
        al = 0;
        st = 0;
        while (n < 200) begin
            @(negedge pclk);
            if (ale === 1'b1) al++;
            if ((we ? wr_n : rd_n) === 1'b0) st++;
            if (core_ready === 1'b1) break;
            n++;
        end
        r = core_rdata;
        @(posedge pclk);
    endtask

    task automatic core_idle();
        core_req <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `CFG_OFFSET, 32'h0);
        `CHK(q, 32'h0000_0000)
        apb(1'b1, 8'h08, 32'hffff_ffff);
        `CHK({e, q}, {1'b1, 32'h0000_0000})
        for (int f = 0; f < 16; f++) begin
            apb(1'b1, `CFG_OFFSET, {26'h0, 1'b1, f[0], f[3:0]});
            ex = 2 + 2 * (16 - f);
            core_op(1'b1, 1'b1, 16'(f), 16'(16'h1230 + f));
            `CHK(n, ex)
            `CHK(al, 2)
            `CHK(st, 2 * (16 - f) - (f[0] ? 0 : 1))
            core_op(1'b1, 1'b0, 16'(f), 16'h0000);
            `CHK(n, ex)
            `CHK(st, 2 * (16 - f) - (f[0] ? 0 : 1))
            `CHK(r, 16'(16'h1230 + f))
            core_idle();
        end
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `CFG_OFFSET, {25'h0, m[1], m[0], 1'b1, 4'hf});
            core_op(1'b1, 1'b1, 16'h0040, 16'h0000);
            core_op(1'b1, 1'b0, 16'h0041, 16'h0000);
            `CHK(n, 4 + (m[0] ? 0 : 2) + 2 * m[1])
            `CHK(r, 16'h5a41)
            core_idle();
        end
        apb(1'b1, `CFG_OFFSET, 32'h0000_0000);
        core_op(1'b0, 1'b0, 16'h0010, 16'h0000);
        `CHK({n, al, st}, {32'd0, 32'd0, 32'd0})
        core_idle();
        apb(1'b1, `CFG_OFFSET, 32'h0000_003f);
        fork
            core_op(1'b1, 1'b0, 16'h0003, 16'h0000);
            begin
                // lands during address latch, before the access is loaded
                apb(1'b1, `CFG_OFFSET, 32'h0000_0030);
            end
        join
        `CHK(n, 4)
        core_idle();
        core_op(1'b1, 1'b0, 16'h0003, 16'h0000);
        `CHK(n, 34)
        core_idle();
        apb(1'b1, `STAT_OFFSET, 32'hffff_ffff);
        apb(1'b0, `STAT_OFFSET, 32'h0);
        `CHK(q, 32'h0000_3000)
        complete_run();
    end
endmodule
